/* hw/oob_host_ctrl.sv */
// Purpose: Host-side out-of-band signalling and link bring-up for a serial ATA link.
// Assumes: PHY sends a Gen1 burst while tx_burst_o is high; primitives arrive on clock_i.
// Notes: rx_burst_i is a squelch level from the line and is synchronised here.
`timescale 1ns/100ps
module oob_host_ctrl
  import oob_host_pkg::*;
#(
  parameter int ALIGN_WAIT_CYC = ALIGN_WAIT_CYC_DEF
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hard_reset_i,
  input wire logic stop_i,
  input wire logic rx_burst_i,
  input wire logic rx_prim_valid_i,
  input wire logic rx_prim_align_i,
  input wire logic [1:0] rx_speed_i,
  output logic tx_burst_o,
  output logic tx_d102_o,
  output logic tx_align_o,
  output logic [1:0] tx_speed_o,
  output logic link_up_o
);
  state_t state;
  logic line_meta;
  logic line_sync;
  logic [4:0] tick;
  logic [2:0] burst_cnt;
  logic [14:0] wait_cnt;
  logic [1:0] nonalign_cnt;
  logic [1:0] speed_seen;
  logic [4:0] idle_run;
  logic init_det;
  logic init_release;
  logic wake_release;
  logic det_clear;
  logic align_seen;
  logic nonalign_seen;
  logic woken;
  logic [4:0] gap_end;

  assign det_clear = (state == ST_RESET);
  assign align_seen = rx_prim_valid_i & rx_prim_align_i;
  assign nonalign_seen = rx_prim_valid_i & ~rx_prim_align_i;
  assign woken = (state != ST_RESET) && (state != ST_QUIET) && (state != ST_WAKE);
  assign gap_end = (state == ST_RESET) ? 5'(RESET_GAP_CYC - 1) : 5'(WAKE_GAP_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
    end else begin
      line_meta <= rx_burst_i;
      line_sync <= line_meta;
    end
  end

  oob_burst_detect #(.GAP_MIN(RESET_GAP_MIN_CYC), .GAP_MAX(RESET_GAP_MAX_CYC)) init_detect (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .clear_i(det_clear),
    .line_i(line_sync),
    .det_o(init_det),
    .release_o(init_release)
  );

  oob_burst_detect #(.GAP_MIN(WAKE_GAP_MIN_CYC), .GAP_MAX(WAKE_GAP_MAX_CYC)) wake_detect (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .clear_i(det_clear),
    .line_i(line_sync),
    .det_o(),
    .release_o(wake_release)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_RESET;
      tick <= 5'h00;
      burst_cnt <= 3'h0;
      tx_burst_o <= 1'b0;
      wait_cnt <= 15'h0000;
    end else if (hard_reset_i && state != ST_RESET) begin
      state <= ST_RESET;
      tick <= 5'h00;
      burst_cnt <= 3'h0;
      tx_burst_o <= 1'b0;
    end else if (init_release && woken) begin
      state <= ST_WAKE;
      tick <= 5'h00;
      burst_cnt <= 3'h0;
      tx_burst_o <= 1'b0;
    end else begin
      unique case (state)
        ST_RESET, ST_WAKE: begin
          if (tx_burst_o) begin
            if (tick == 5'(BURST_CYC - 1)) begin
              tx_burst_o <= 1'b0;
              tick <= 5'h00;
              if (burst_cnt != 3'h7) begin
                burst_cnt <= burst_cnt + 3'h1;
              end
            end else begin
              tick <= tick + 5'h01;
            end
          end else if (state == ST_RESET && burst_cnt >= SEND_BURSTS && !hard_reset_i) begin
            state <= ST_QUIET;
            tick <= 5'h00;
          end else if (state == ST_WAKE && burst_cnt == SEND_BURSTS) begin
            state <= ST_WAIT_WAKE;
          end else if (tick == gap_end) begin
            tx_burst_o <= 1'b1;
            tick <= 5'h00;
          end else begin
            tick <= tick + 5'h01;
          end
        end
        ST_QUIET: begin
          if (tick == 5'(RESET_QUIET_CYC - 1)) begin
            state <= ST_WAIT_INIT;
          end else begin
            tick <= tick + 5'h01;
          end
        end
        ST_WAIT_INIT: begin
          if (init_release) begin
            state <= ST_WAKE;
            tick <= 5'h00;
            burst_cnt <= 3'h0;
          end
        end
        ST_WAIT_WAKE: begin
          if (wake_release) begin
            state <= ST_WAIT_ALIGN;
            wait_cnt <= 15'h0000;
          end
        end
        ST_WAIT_ALIGN: begin
          if (align_seen) begin
            state <= ST_SEND_ALIGN;
          end else if (wait_cnt == 15'(ALIGN_WAIT_CYC - 1)) begin
            state <= stop_i ? ST_HALT : ST_RESET;
            tick <= 5'h00;
            burst_cnt <= 3'h0;
          end else begin
            wait_cnt <= wait_cnt + 15'h0001;
          end
        end
        ST_SEND_ALIGN: begin
          if (nonalign_seen && nonalign_cnt == NONALIGN_RUN - 2'h1) begin
            state <= ST_LINK_UP;
          end
        end
        ST_LINK_UP, ST_HALT: begin
          state <= state;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (srst_i || state != ST_SEND_ALIGN) begin
      nonalign_cnt <= 2'h0;
    end else if (align_seen) begin
      nonalign_cnt <= 2'h0;
    end else if (nonalign_seen && nonalign_cnt != NONALIGN_RUN) begin
      nonalign_cnt <= nonalign_cnt + 2'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      speed_seen <= SPEED_LOWEST;
    end else if (state == ST_WAIT_ALIGN && align_seen) begin
      speed_seen <= rx_speed_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_d102_o <= 1'b0;
      tx_align_o <= 1'b0;
      tx_speed_o <= SPEED_LOWEST;
      link_up_o <= 1'b0;
    end else begin
      tx_d102_o <= (state == ST_WAIT_ALIGN);
      tx_align_o <= (state == ST_SEND_ALIGN) || (state == ST_LINK_UP);
      tx_speed_o <= (state == ST_SEND_ALIGN || state == ST_LINK_UP) ? speed_seen : SPEED_LOWEST;
      link_up_o <= (state == ST_LINK_UP);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || tx_burst_o) begin
      idle_run <= 5'h00;
    end else if (idle_run != 5'h1F) begin
      idle_run <= idle_run + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  burst_length_a: assert property (@(posedge clock_i) disable iff (srst_i || hard_reset_i)
    $rose(tx_burst_o) |-> tx_burst_o[*3] ##1 !tx_burst_o)
    else $error("Burst length is not three cycles.");
  reset_gap_a: assert property (@(posedge clock_i) disable iff (srst_i || hard_reset_i)
    ($fell(tx_burst_o) && state == ST_RESET) |-> (!tx_burst_o)[*8])
    else $error("Reset idle gap shorter than eight cycles.");
  wake_gap_a: assert property (@(posedge clock_i) disable iff (srst_i || hard_reset_i)
    ($fell(tx_burst_o) && state == ST_WAKE && burst_cnt != SEND_BURSTS) |->
      (!tx_burst_o)[*3] ##1 tx_burst_o)
    else $error("Wake idle gap is not three cycles.");
  six_bursts_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(state == ST_QUIET) |-> burst_cnt >= SEND_BURSTS && !$past(hard_reset_i))
    else $error("Reset pattern ended before six bursts.");
  quiet_after_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(state == ST_WAIT_INIT) |-> idle_run >= 5'(RESET_QUIET_CYC))
    else $error("Line not idle long enough after reset pattern.");
  hold_reset_a: assert property (@(posedge clock_i) disable iff (srst_i)
    hard_reset_i |=> state == ST_RESET)
    else $error("System reset did not hold the reset pattern.");
  ignore_device_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (state == ST_RESET && $past(state == ST_RESET)) |-> !init_det && !init_release)
    else $error("Device signal seen during reset pattern.");
  lowest_rate_a: assert property (@(posedge clock_i) disable iff (srst_i)
    tx_d102_o |-> tx_speed_o == SPEED_LOWEST && !tx_align_o)
    else $error("D10.2 sent above the lowest rate.");
  align_reply_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (state == ST_WAIT_ALIGN && align_seen && !hard_reset_i && !init_release) |->
      ##2 tx_align_o && tx_speed_o == $past(rx_speed_i, 2))
    else $error("ALIGN not returned at the received speed.");
  align_timeout_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (state == ST_WAIT_ALIGN && wait_cnt == 15'(ALIGN_WAIT_CYC - 1) && !align_seen &&
      !hard_reset_i && !init_release && !stop_i) |=> state == ST_RESET)
    else $error("No restart after ALIGN wait expired.");
  link_up_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (state == ST_SEND_ALIGN && nonalign_seen && nonalign_cnt == 2'h2 && !hard_reset_i &&
      !init_release) |-> ##2 link_up_o)
    else $error("Link not up after three non-ALIGN primitives.");

  link_up_c: cover property (@(posedge clock_i) disable iff (srst_i) $rose(link_up_o));
  restart_c: cover property (@(posedge clock_i) disable iff (srst_i)
    state == ST_WAIT_ALIGN ##1 state == ST_RESET);
  init_seen_c: cover property (@(posedge clock_i) disable iff (srst_i) init_release);
  wake_seen_c: cover property (@(posedge clock_i) disable iff (srst_i)
    state == ST_WAIT_WAKE && wake_release);
endmodule

/* hw/oob_host_pkg.sv */
// Purpose: Shared constants and types for the host-side out-of-band link bring-up.
// Assumes: A 25 MHz clock; the PHY turns a burst request into Gen1 burst patterns.
// Notes: Cycle counts are derived from the printed times in nanoseconds, and in microseconds for the ALIGN wait.
package oob_host_pkg;
  localparam real CLK_NS = 40.0;
  localparam real BURST_NS = 106.7;
  localparam real RESET_GAP_NS = 320.0;
  localparam real RESET_GAP_MIN_NS = 175.0;
  localparam real RESET_GAP_MAX_NS = 525.0;
  localparam real RESET_QUIET_NS = 525.0;
  localparam real WAKE_GAP_NS = 106.7;
  localparam real WAKE_GAP_MIN_NS = 35.0;
  localparam real WAKE_GAP_MAX_NS = 175.0;
  localparam real ALIGN_WAIT_US = 873.8;
  localparam int BURST_CYC = int'($ceil(BURST_NS / CLK_NS));
  localparam int RESET_GAP_CYC = int'($ceil(RESET_GAP_NS / CLK_NS));
  localparam int RESET_GAP_MIN_CYC = int'($ceil(RESET_GAP_MIN_NS / CLK_NS));
  localparam int RESET_GAP_MAX_CYC = int'($floor(RESET_GAP_MAX_NS / CLK_NS));
  localparam int RESET_QUIET_CYC = int'($ceil(RESET_QUIET_NS / CLK_NS));
  localparam int WAKE_GAP_CYC = int'($ceil(WAKE_GAP_NS / CLK_NS));
  localparam int WAKE_GAP_MIN_CYC = int'($ceil(WAKE_GAP_MIN_NS / CLK_NS));
  localparam int WAKE_GAP_MAX_CYC = int'($floor(WAKE_GAP_MAX_NS / CLK_NS));
  localparam int ALIGN_WAIT_CYC_DEF = int'($ceil(ALIGN_WAIT_US * 1000.0 / CLK_NS));
  localparam logic [2:0] SEND_BURSTS = 3'h6;
  localparam logic [2:0] DETECT_BURSTS = 3'h4;
  localparam logic [1:0] NONALIGN_RUN = 2'h3;
  localparam logic [1:0] SPEED_LOWEST = 2'h0;
  typedef enum logic [3:0] {
    ST_RESET,
    ST_QUIET,
    ST_WAIT_INIT,
    ST_WAKE,
    ST_WAIT_WAKE,
    ST_WAIT_ALIGN,
    ST_SEND_ALIGN,
    ST_LINK_UP,
    ST_HALT
  } state_t;
endpackage

/* hw/oob_burst_detect.sv */
// Purpose: Recognises four bursts whose idle gaps lie in a window, and its release.
// Assumes: The line input is already synchronised to clock_i.
// Notes: A gap outside the window restarts the count at the burst that ended it.
`timescale 1ns/100ps
module oob_burst_detect
  import oob_host_pkg::*;
#(
  parameter int GAP_MIN = 1,
  parameter int GAP_MAX = 4
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic line_i,
  output logic det_o,
  output logic release_o
);
  logic prev;
  logic [4:0] gap_cnt;
  logic [2:0] burst_cnt;
  logic rise;

  assign rise = line_i & ~prev;
  assign det_o = (burst_cnt == DETECT_BURSTS);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prev <= 1'b0;
      gap_cnt <= 5'h00;
    end else begin
      prev <= line_i;
      if (line_i) begin
        gap_cnt <= 5'h00;
      end else if (gap_cnt != 5'h1F) begin
        gap_cnt <= gap_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || clear_i) begin
      burst_cnt <= 3'h0;
      release_o <= 1'b0;
    end else begin
      release_o <= 1'b0;
      if (rise) begin
        if (gap_cnt >= 5'(GAP_MIN) && gap_cnt <= 5'(GAP_MAX) && burst_cnt != 3'h0) begin
          if (burst_cnt != DETECT_BURSTS) begin
            burst_cnt <= burst_cnt + 3'h1;
          end
        end else begin
          burst_cnt <= 3'h1;
        end
      end else if (!line_i && gap_cnt == 5'(GAP_MAX + 1)) begin
        burst_cnt <= 3'h0;
        release_o <= det_o;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  count_four_a: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(det_o) |-> $past(burst_cnt) == 3'h3 && $past(rise))
    else $error("Pattern recognised without four bursts.");
  gap_reject_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (rise && !clear_i && (gap_cnt < 5'(GAP_MIN) || gap_cnt > 5'(GAP_MAX))) |=>
      burst_cnt == 3'h1)
    else $error("Out-of-window gap did not restart the count.");
endmodule

/* sim/oob_dev_model.sv */
// Purpose: Device-side partner that answers the host's out-of-band bring-up.
// Assumes: line_i is the host's burst line; primitives leave as one-cycle strobes.
// Notes: silent_i withholds ALIGN; bad_gap_i spaces init bursts too widely.
`timescale 1ns/100ps
module oob_dev_model #(
  parameter int STEP_CYC = 40
) (
  input wire logic clock_i,
  input wire logic line_i,
  input wire logic align_seen_i,
  input wire logic silent_i,
  input wire logic bad_gap_i,
  output logic burst_o,
  output logic prim_valid_o,
  output logic prim_align_o,
  output logic [1:0] speed_o
);
  int low_run = 0;
  int last_gap = 0;
  logic seen = 1'b0;
  logic [1:0] speed = 2'h2;
  ////////////////////////////////////////////////////////////////////////////////
  // Spots the end of a host pattern and keeps its spacing.
  always @(posedge clock_i) begin
    if (line_i) begin
      seen <= 1'b1;
      low_run <= 0;
      if (low_run > 0 && low_run < 14) last_gap <= low_run;
    end else begin
      low_run <= low_run + 1;
      if (low_run == 14) seen <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sends six bursts of three cycles with the given gap.
  task automatic train(input int gap);
    repeat (6) begin
      burst_o <= 1'b1;
      repeat (3) @(posedge clock_i);
      burst_o <= 1'b0;
      repeat (gap) @(posedge clock_i);
    end
  endtask
  // Streams ALIGN, stepping down in speed, then answers a returned ALIGN with SYNC.
  task automatic send_align();
    int t;
    t = 0;
    speed = 2'h2;
    while (!align_seen_i && !line_i) begin
      prim_valid_o <= !silent_i;
      prim_align_o <= 1'b1;
      speed_o <= silent_i ? ~speed : speed;
      @(posedge clock_i);
      t++;
      if (t == STEP_CYC) begin
        if (speed == 2'h0) break;
        speed = speed - 2'h1;
        t = 0;
      end
    end
    if (align_seen_i) begin
      prim_valid_o <= 1'b1;
      prim_align_o <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    prim_valid_o <= 1'b0;
    speed_o <= ~speed;
  endtask
  initial begin
    int idle;
    burst_o = 1'b0;
    prim_valid_o = 1'b0;
    prim_align_o = 1'b0;
    speed_o = 2'h1;
    forever begin
      idle = 0;
      while (!(seen && low_run == 14) && (idle < 300 || align_seen_i)) begin
        @(posedge clock_i);
        idle++;
      end
      if (seen && low_run == 14 && last_gap < 6) begin
        train(3);
        send_align();
      end else begin
        train(bad_gap_i ? 16 : 8);
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the host out-of-band controller.
// Assumes: A shortened ALIGN wait of 64 cycles.
// Notes: Outputs are sampled on the falling edge.
`timescale 1ns/100ps
module tb_top;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hard_reset_i = 1'b0;
  logic stop_i = 1'b0;
  logic silent = 1'b0;
  logic bad_gap = 1'b0;
  logic rx_burst_i;
  logic rx_prim_valid_i;
  logic rx_prim_align_i;
  logic [1:0] rx_speed_i;
  logic [1:0] tx_speed_o;
  logic tx_burst_o;
  logic tx_d102_o;
  logic tx_align_o;
  logic link_up_o;
  int num_errors = 0;
  int total_checks = 0;
  int low_run = 0;
  int host_gap = 0;
  always #20 clock_i = ~clock_i;
  oob_host_ctrl #(.ALIGN_WAIT_CYC(64)) i_oob_host_ctrl (.clock_i(clock_i), .srst_i(srst_i),
    .hard_reset_i(hard_reset_i), .stop_i(stop_i), .rx_burst_i(rx_burst_i),
    .rx_prim_valid_i(rx_prim_valid_i), .rx_prim_align_i(rx_prim_align_i),
    .rx_speed_i(rx_speed_i), .tx_burst_o(tx_burst_o), .tx_d102_o(tx_d102_o),
    .tx_align_o(tx_align_o), .tx_speed_o(tx_speed_o), .link_up_o(link_up_o));
  oob_dev_model i_oob_dev_model (.clock_i(clock_i), .line_i(tx_burst_o),
    .align_seen_i(tx_align_o), .silent_i(silent), .bad_gap_i(bad_gap),
    .burst_o(rx_burst_i), .prim_valid_o(rx_prim_valid_i),
    .prim_align_o(rx_prim_align_i), .speed_o(rx_speed_i));
  ////////////////////////////////////////////////////////////////////////////////
  // Measures the idle run before each host burst.
  always @(negedge clock_i) begin
    if (tx_burst_o === 1'b1) begin
      if (low_run > 0) host_gap = low_run;
      low_run = 0;
    end else begin
      low_run = low_run + 1;
    end
  end
  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_vec(input string what, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Counts host bursts over a number of cycles.
  task automatic count_bursts(input int cycles, output int n);
    logic prev;
    prev = tx_burst_o;
    n = 0;
    repeat (cycles) begin
      @(negedge clock_i);
      if (tx_burst_o === 1'b1 && prev !== 1'b1) n++;
      prev = tx_burst_o;
    end
  endtask
  task automatic wait_d102();
    int n;
    n = 0;
    while (tx_d102_o !== 1'b1 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    check_bit("d102 sent", 1'b1, tx_d102_o);
    check_vec("d102 speed", 2'h0, tx_speed_o);
    if (tx_d102_o !== 1'b1) print_verdict();
  endtask
  task automatic wait_link();
    int n;
    n = 0;
    while (link_up_o !== 1'b1 && n < 1000) begin
      @(negedge clock_i);
      n++;
    end
    check_bit("link up", 1'b1, link_up_o);
    check_bit("align returned", 1'b1, tx_align_o);
    check_bit("d102 off", 1'b0, tx_d102_o);
    check_vec("align speed", 2'h2, tx_speed_o);
    check_num("wake gap", 3, host_gap);
    if (link_up_o !== 1'b1) print_verdict();
  endtask
  task automatic s_reset_pattern();
    @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    for (int c = 0; c <= 80; c++) begin
      @(negedge clock_i);
      check_bit("burst", c >= 7 && c <= 64 && (c - 7) % 11 <= 2, tx_burst_o);
    end
    wait_link();
  endtask
  task automatic s_hard_reset();
    int n;
    @(posedge clock_i);
    hard_reset_i <= 1'b1;
    count_bursts(100, n);
    check_bit("link dropped", 1'b0, link_up_o);
    check_bit("held bursts", 1'b1, n >= 8);
    @(posedge clock_i);
    hard_reset_i <= 1'b0;
    wait_link();
  endtask
  task automatic s_bad_gap();
    int n;
    @(posedge clock_i);
    bad_gap <= 1'b1;
    hard_reset_i <= 1'b1;
    @(posedge clock_i);
    hard_reset_i <= 1'b0;
    count_bursts(120, n);
    check_num("reset bursts", 6, n);
    count_bursts(150, n);
    check_num("wake on bad init", 0, n);
    @(posedge clock_i);
    bad_gap <= 1'b0;
    wait_link();
  endtask
  task automatic s_timeout_stop();
    int n;
    @(posedge clock_i);
    silent <= 1'b1;
    hard_reset_i <= 1'b1;
    @(posedge clock_i);
    hard_reset_i <= 1'b0;
    wait_d102();
    n = 0;
    while (tx_burst_o !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    check_bit("align timeout", 1'b1, n >= 64 && n <= 80);
    if (tx_burst_o !== 1'b1) print_verdict();
    @(posedge clock_i);
    stop_i <= 1'b1;
    wait_d102();
    count_bursts(150, n);
    check_num("halt bursts", 0, n);
    @(posedge clock_i);
    stop_i <= 1'b0;
    silent <= 1'b0;
    wait_link();
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    s_reset_pattern();
    s_hard_reset();
    s_bad_gap();
    s_timeout_stop();
    print_verdict();
  end
endmodule
